// ### shared/ddcns_map.svh
// register offsets, field positions, reset values for the downconverter sync control
`ifndef DDCNS_MAP_SVH
`define DDCNS_MAP_SVH

// register offsets
`define DDCNS_OFF_OSC_CTRL     8'h51
`define DDCNS_OFF_TUNE_B3      8'h52
`define DDCNS_OFF_TUNE_B2      8'h53
`define DDCNS_OFF_TUNE_B1      8'h54
`define DDCNS_OFF_TUNE_B0      8'h55
`define DDCNS_OFF_PHASE_HI     8'h56
`define DDCNS_OFF_PHASE_LO     8'h57
`define DDCNS_OFF_ALIGN_CTRL   8'h58
`define DDCNS_OFF_ALIGN_PIN    8'h59
`define DDCNS_OFF_OSC_CTRL2    8'h5a

// oscillator control fields
`define DDCNS_OSC_QSYNC_BIT    6
`define DDCNS_OSC_SPECREV_BIT  5
`define DDCNS_OSC_AMPDITH_BIT  2
`define DDCNS_OSC_PHDITH_BIT   1
`define DDCNS_OSC_RD_ONES      8'h11
`define DDCNS_OSC_WMASK        8'h66

// alignment control fields
`define DDCNS_ALN_QONCE_BIT    7
`define DDCNS_ALN_QEN_BIT      6
`define DDCNS_ALN_FONCE_BIT    5
`define DDCNS_ALN_FEN_BIT      4
`define DDCNS_ALN_TONCE_BIT    1
`define DDCNS_ALN_TEN_BIT      0
`define DDCNS_ALN_WMASK        8'hf3

// pin control fields
`define DDCNS_PIN_EDGE_BIT     1
`define DDCNS_PIN_RISE_BIT     0
`define DDCNS_PIN_WMASK        8'h03

// second oscillator control fields
`define DDCNS_OSC2_LOWLAT_BIT  0
`define DDCNS_OSC2_WMASK       8'h01

// reset values
`define DDCNS_RST_OSC_CTRL     8'h00
`define DDCNS_RST_BYTE         8'h00
`define DDCNS_RST_ALIGN_CTRL   8'h00
`define DDCNS_RST_ALIGN_PIN    8'h00
`define DDCNS_RST_OSC_CTRL2    8'h01
`define DDCNS_RD_UNMAPPED      8'h00

`endif

// ### shared/ddcns_pkg.sv
// types shared by the downconverter sync control modules
package ddcns_pkg;

  // how the alignment input is turned into pulses
  typedef enum logic [1:0]
  {
    DDCNS_DET_LEVEL   = 2'b00,
    DDCNS_DET_FALLING = 2'b01,
    DDCNS_DET_RISING  = 2'b11
  } ddcns_detect_t;

endpackage

// ### rtl/ddcns_align_det.sv
// alignment input synchroniser and level / edge pulse detector
`timescale 1ns/100ps
`default_nettype none

module ddcns_align_det
  import ddcns_pkg::*;
(
  input  wire logic                    clock_i,  // sample clock
  input  wire logic                    nrst_i,   // async reset, active low
  input  wire logic                    ce_i,     // clock enable
  input  wire logic                    pin_i,    // raw alignment pin
  input  wire ddcns_pkg::ddcns_detect_t mode_i,  // detection mode
  output logic                         pulse_o   // accepted pulse, one cycle per edge, held while the pin is high in level mode
);

  // synchroniser stages, history and pulse register
  logic meta_reg;   // first stage, read only by second stage
  logic meta_next;
  logic sync_reg;   // second stage, safe to read
  logic sync_next;
  logic prev_reg;   // previous synchronised level
  logic prev_next;
  logic pulse_reg;  // registered pulse
  logic pulse_next;

  // next-state: sync chain and detection on synchronised level
  always_comb
  begin
    meta_next  = pin_i;
    sync_next  = meta_reg;
    prev_next  = sync_reg;
    unique case (mode_i)
      DDCNS_DET_LEVEL:   pulse_next = sync_reg;
      DDCNS_DET_FALLING: pulse_next = prev_reg & ~sync_reg;
      DDCNS_DET_RISING:  pulse_next = ~prev_reg & sync_reg;
      default:           pulse_next = 1'b0;                   // illegal code
    endcase
  end

  // registers, frozen while clock enable is low
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_reg  <= 1'b0;
      sync_reg  <= 1'b0;
      prev_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      meta_reg  <= meta_next;
      sync_reg  <= sync_next;
      prev_reg  <= prev_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse_o = pulse_reg;

endmodule

`default_nettype wire

// ### rtl/ddcns_ctrl.sv
// register bank and alignment gating for the downconverter oscillators and filter
//
// Behaviour
// - bit 2 enables tunable oscillator amplitude dither
// - bit 1 enables tunable oscillator phase dither
// - oscillator control bit 0 reads as one
// - tuning word from bytes 0x52 (msb) to 0x55
// - tuning word is two's complement
// - phase offset loads on start and accepted pulse
// - quarter-rate one-shot aligns once, clears bit 6
// - bit 6 passes pulses to quarter-rate oscillator
// - filter one-shot aligns once, clears bit 4
// - bit 4 passes pulses to the filter
// - tunable one-shot aligns once, clears bit 0
// - bit 0 restarts accumulator from phase offset
// - pin bit 1 selects level or edge
// - pin bit 0 selects falling or rising edge
// - second control bit 0 selects low-latency path
// - master sync enable gates every sync function
// - sync control resets 0x00, control two 0x01
`timescale 1ns/100ps
`default_nettype none
`include "ddcns_map.svh"

module ddcns_ctrl
  import ddcns_pkg::*;
#(
  parameter int TUNE_W  = 32,  // tuning word width
  parameter int PHASE_W = 16   // phase offset width
)
(
  input  wire logic               clock_i,            // sample clock, 100 MHz
  input  wire logic               nrst_i,             // async reset, active low
  input  wire logic               ce_i,               // clock enable, freezes state
  input  wire logic [7:0]         reg_addr_i,         // register offset
  input  wire logic [7:0]         reg_wdata_i,        // write data
  input  wire logic               reg_wr_i,           // write strobe, one cycle
  input  wire logic               reg_rd_i,           // read strobe, one cycle
  output logic      [7:0]         reg_rdata_o,        // read data, next cycle
  input  wire logic               master_sync_en_i,   // master sync buffer enable
  input  wire logic               osc_start_i,        // oscillator start pulse
  input  wire logic               align_pin_i,        // external alignment pin
  output logic                    amp_dither_en_o,    // amplitude dither enable
  output logic                    phase_dither_en_o,  // phase dither enable
  output logic                    spectral_rev_o,     // spectral reversal
  output logic                    quarter_link_en_o,  // tunable to quarter-rate sync
  output logic                    low_latency_sel_o,  // low-latency path select
  output logic signed [TUNE_W-1:0] tuning_word_o,     // signed tuning word
  output logic      [PHASE_W-1:0] phase_offset_o,     // phase offset word
  output logic                    accum_load_o,       // load accumulator with offset
  output logic                    quarter_sync_o,     // quarter-rate oscillator sync
  output logic                    filter_sync_o       // half-band filter sync
);

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [7:0]        osc_ctrl_reg;      // oscillator control, writable bits
  logic [7:0]        osc_ctrl_next;
  logic [TUNE_W-1:0] tuning_reg;        // assembled tuning word
  logic [TUNE_W-1:0] tuning_next;
  logic [PHASE_W-1:0] phase_reg;        // assembled phase offset
  logic [PHASE_W-1:0] phase_next;
  logic [7:0]        align_ctrl_reg;    // alignment control
  logic [7:0]        align_ctrl_next;
  logic [7:0]        align_pin_reg;     // pin detection control
  logic [7:0]        align_pin_next;
  logic [7:0]        osc_ctrl2_reg;     // second oscillator control
  logic [7:0]        osc_ctrl2_next;
  logic [7:0]        rdata_reg;         // registered read data
  logic [7:0]        rdata_next;

  // ------------------------------------------------------------------
  // sync output registers
  // ------------------------------------------------------------------
  logic              accum_load_reg;    // accumulator load pulse
  logic              accum_load_next;
  logic              quarter_sync_reg;  // quarter-rate sync pulse
  logic              quarter_sync_next;
  logic              filter_sync_reg;   // filter sync pulse
  logic              filter_sync_next;

  // detector interface
  ddcns_detect_t     det_mode;          // decoded detection mode
  logic              align_pulse;       // accepted pin pulse, one cycle in edge modes, held in level mode

  // per-function accepted pulses
  logic              tune_hit;          // pulse reaches tunable oscillator
  logic              quarter_hit;       // pulse reaches quarter-rate oscillator
  logic              filter_hit;        // pulse reaches filter

  // write decode strobes
  logic              wr_osc;
  logic              wr_align;

  // ------------------------------------------------------------------
  // detection mode from pin control bits
  // ------------------------------------------------------------------
  always_comb
  begin
    if (!align_pin_reg[`DDCNS_PIN_EDGE_BIT])
    begin
      det_mode = DDCNS_DET_LEVEL;
    end
    else if (align_pin_reg[`DDCNS_PIN_RISE_BIT])
    begin
      det_mode = DDCNS_DET_RISING;
    end
    else
    begin
      det_mode = DDCNS_DET_FALLING;
    end
  end

  // synchroniser and pulse detector for the alignment pin
  ddcns_align_det u_det
  (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .ce_i    (ce_i),
    .pin_i   (align_pin_i),
    .mode_i  (det_mode),
    .pulse_o (align_pulse)
  );

  // ------------------------------------------------------------------
  // gating of the accepted pulse per function
  // ------------------------------------------------------------------
  always_comb
  begin
    // master enable qualifies everything
    tune_hit    = align_pulse & master_sync_en_i
                & align_ctrl_reg[`DDCNS_ALN_TEN_BIT];
    quarter_hit = align_pulse & master_sync_en_i
                & align_ctrl_reg[`DDCNS_ALN_QEN_BIT];
    filter_hit  = align_pulse & master_sync_en_i
                & align_ctrl_reg[`DDCNS_ALN_FEN_BIT];
  end

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  always_comb
  begin
    wr_osc   = reg_wr_i & (reg_addr_i == `DDCNS_OFF_OSC_CTRL);
    wr_align = reg_wr_i & (reg_addr_i == `DDCNS_OFF_ALIGN_CTRL);
  end

  // ------------------------------------------------------------------
  // register next values: software writes and one-shot self-clear
  // ------------------------------------------------------------------
  always_comb
  begin
    osc_ctrl_next   = osc_ctrl_reg;
    tuning_next     = tuning_reg;
    phase_next      = phase_reg;
    align_ctrl_next = align_ctrl_reg;
    align_pin_next  = align_pin_reg;
    osc_ctrl2_next  = osc_ctrl2_reg;

    // oscillator control keeps bits 6, 5, 2, 1; bit 0 is reserved
    if (wr_osc)
    begin
      osc_ctrl_next = reg_wdata_i & `DDCNS_OSC_WMASK;
    end

    // tuning word and phase offset bytes, most significant first, then pin and second control
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        `DDCNS_OFF_TUNE_B3:  tuning_next[31:24] = reg_wdata_i;
        `DDCNS_OFF_TUNE_B2:  tuning_next[23:16] = reg_wdata_i;
        `DDCNS_OFF_TUNE_B1:  tuning_next[15:8]  = reg_wdata_i;
        `DDCNS_OFF_TUNE_B0:  tuning_next[7:0]   = reg_wdata_i;
        `DDCNS_OFF_PHASE_HI: phase_next[15:8]   = reg_wdata_i;
        `DDCNS_OFF_PHASE_LO: phase_next[7:0]    = reg_wdata_i;
        `DDCNS_OFF_ALIGN_PIN:
          align_pin_next = reg_wdata_i & `DDCNS_PIN_WMASK;
        `DDCNS_OFF_OSC_CTRL2:
          osc_ctrl2_next = reg_wdata_i & `DDCNS_OSC2_WMASK;
        default: ;                                              // other offsets
      endcase
    end

    // one-shot modes drop their enable after the first pulse
    if (quarter_hit && align_ctrl_reg[`DDCNS_ALN_QONCE_BIT])
    begin
      align_ctrl_next[`DDCNS_ALN_QEN_BIT] = 1'b0;
    end
    if (filter_hit && align_ctrl_reg[`DDCNS_ALN_FONCE_BIT])
    begin
      align_ctrl_next[`DDCNS_ALN_FEN_BIT] = 1'b0;
    end
    if (tune_hit && align_ctrl_reg[`DDCNS_ALN_TONCE_BIT])
    begin
      align_ctrl_next[`DDCNS_ALN_TEN_BIT] = 1'b0;
    end

    // a software write in the same cycle carries newer intent and wins
    if (wr_align)
    begin
      align_ctrl_next = reg_wdata_i & `DDCNS_ALN_WMASK;
    end
  end

  // ------------------------------------------------------------------
  // read data: reserved bits zero except the read-as-one bits
  // ------------------------------------------------------------------
  always_comb
  begin
    rdata_next = rdata_reg;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `DDCNS_OFF_OSC_CTRL:
          rdata_next = osc_ctrl_reg | `DDCNS_OSC_RD_ONES;
        `DDCNS_OFF_TUNE_B3:    rdata_next = tuning_reg[31:24];
        `DDCNS_OFF_TUNE_B2:    rdata_next = tuning_reg[23:16];
        `DDCNS_OFF_TUNE_B1:    rdata_next = tuning_reg[15:8];
        `DDCNS_OFF_TUNE_B0:    rdata_next = tuning_reg[7:0];
        `DDCNS_OFF_PHASE_HI:   rdata_next = phase_reg[15:8];
        `DDCNS_OFF_PHASE_LO:   rdata_next = phase_reg[7:0];
        `DDCNS_OFF_ALIGN_CTRL: rdata_next = align_ctrl_reg;
        `DDCNS_OFF_ALIGN_PIN:  rdata_next = align_pin_reg;
        `DDCNS_OFF_OSC_CTRL2:  rdata_next = osc_ctrl2_reg;
        default:               rdata_next = `DDCNS_RD_UNMAPPED;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // sync pulse outputs, registered one cycle after the accepted pulse
  // ------------------------------------------------------------------
  always_comb
  begin
    accum_load_next   = osc_start_i | tune_hit;
    quarter_sync_next = quarter_hit;
    filter_sync_next  = filter_hit;
  end

  // ------------------------------------------------------------------
  // register bank flops
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      osc_ctrl_reg   <= `DDCNS_RST_OSC_CTRL;
      tuning_reg     <= '0;
      phase_reg      <= '0;
      align_ctrl_reg <= `DDCNS_RST_ALIGN_CTRL;
      align_pin_reg  <= `DDCNS_RST_ALIGN_PIN;
      osc_ctrl2_reg  <= `DDCNS_RST_OSC_CTRL2;
      rdata_reg      <= `DDCNS_RD_UNMAPPED;
    end
    else if (ce_i)
    begin
      osc_ctrl_reg   <= osc_ctrl_next;
      tuning_reg     <= tuning_next;
      phase_reg      <= phase_next;
      align_ctrl_reg <= align_ctrl_next;
      align_pin_reg  <= align_pin_next;
      osc_ctrl2_reg  <= osc_ctrl2_next;
      rdata_reg      <= rdata_next;
    end
  end

  // ------------------------------------------------------------------
  // sync pulse flops
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      accum_load_reg   <= 1'b0;
      quarter_sync_reg <= 1'b0;
      filter_sync_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      accum_load_reg   <= accum_load_next;
      quarter_sync_reg <= quarter_sync_next;
      filter_sync_reg  <= filter_sync_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs straight from flops
  // ------------------------------------------------------------------
  assign reg_rdata_o       = rdata_reg;
  assign amp_dither_en_o   = osc_ctrl_reg[`DDCNS_OSC_AMPDITH_BIT];
  assign phase_dither_en_o = osc_ctrl_reg[`DDCNS_OSC_PHDITH_BIT];
  assign spectral_rev_o    = osc_ctrl_reg[`DDCNS_OSC_SPECREV_BIT];
  assign quarter_link_en_o = osc_ctrl_reg[`DDCNS_OSC_QSYNC_BIT];
  assign low_latency_sel_o = osc_ctrl2_reg[`DDCNS_OSC2_LOWLAT_BIT];
  // signed view, negative offsets pass straight through
  assign tuning_word_o     = $signed(tuning_reg);
  assign phase_offset_o    = phase_reg;
  assign accum_load_o      = accum_load_reg;
  assign quarter_sync_o    = quarter_sync_reg;
  assign filter_sync_o     = filter_sync_reg;

endmodule

`default_nettype wire

// ### tb/ddcns_ctrl_monitor.sv
// concurrent checks on the ports of the downconverter sync control
`timescale 1ns/100ps
`default_nettype none

module ddcns_ctrl_monitor
#(
  parameter int TUNE_W  = 32,  // tuning word width
  parameter int PHASE_W = 16   // phase offset width
)
(
  input  wire logic               clock_i,           // sample clock
  input  wire logic               nrst_i,            // async reset, active low
  input  wire logic               ce_i,              // clock enable
  input  wire logic [7:0]         reg_addr_i,        // register offset
  input  wire logic [7:0]         reg_wdata_i,       // write data
  input  wire logic               reg_wr_i,          // write strobe
  input  wire logic               reg_rd_i,          // read strobe
  input  wire logic [7:0]         reg_rdata_o,       // read data
  input  wire logic               master_sync_en_i,  // master sync enable
  input  wire logic               osc_start_i,       // oscillator start
  input  wire logic               amp_dither_en_o,   // amplitude dither
  input  wire logic               phase_dither_en_o, // phase dither
  input  wire logic               low_latency_sel_o, // low-latency select
  input  wire logic signed [TUNE_W-1:0] tuning_word_o, // tuning word
  input  wire logic [PHASE_W-1:0] phase_offset_o,    // phase offset
  input  wire logic               accum_load_o,      // accumulator load
  input  wire logic               quarter_sync_o,    // quarter-rate sync
  input  wire logic               filter_sync_o      // filter sync
);
  // write and read strobes that the block takes
  logic wr_ok;  // write taken this edge
  logic rd_ok;  // read taken this edge
  assign wr_ok = ce_i && reg_wr_i;
  assign rd_ok = ce_i && reg_rd_i;

  // one clock domain for all checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  chk_amp_dither: assert property (wr_ok && reg_addr_i == 8'h51 |=>
    amp_dither_en_o == $past(reg_wdata_i[2])) else $error("amplitude dither not updated");
  chk_phase_dither: assert property (wr_ok && reg_addr_i == 8'h51 |=>
    phase_dither_en_o == $past(reg_wdata_i[1])) else $error("phase dither not updated");
  chk_tune_msb: assert property (wr_ok && reg_addr_i == 8'h52 |=>
    tuning_word_o[31:24] == $past(reg_wdata_i)) else $error("tuning msb not updated");
  chk_tune_lsb: assert property (wr_ok && reg_addr_i == 8'h55 |=>
    tuning_word_o[7:0] == $past(reg_wdata_i)) else $error("tuning lsb not updated");
  chk_phase_high: assert property (wr_ok && reg_addr_i == 8'h56 |=>
    phase_offset_o[15:8] == $past(reg_wdata_i)) else $error("phase high not updated");
  chk_start_load: assert property (ce_i && osc_start_i |=> accum_load_o)
    else $error("start did not load accumulator");
  chk_low_latency: assert property (wr_ok && reg_addr_i == 8'h5a |=>
    low_latency_sel_o == $past(reg_wdata_i[0])) else $error("low-latency select wrong");
  chk_osc_ones: assert property (rd_ok && reg_addr_i == 8'h51 |=>
    reg_rdata_o[0] && reg_rdata_o[4]) else $error("fixed ones missing");
  chk_unmapped_zero: assert property (rd_ok && (reg_addr_i < 8'h51 || reg_addr_i > 8'h5a)
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_sync_gate: assert property ((quarter_sync_o || filter_sync_o) && $past(ce_i)
    |-> $past(master_sync_en_i)) else $error("sync pulse without master enable");
  chk_load_cause: assert property (accum_load_o && $past(ce_i)
    |-> $past(osc_start_i) || $past(master_sync_en_i)) else $error("load without cause");
endmodule

bind ddcns_ctrl ddcns_ctrl_monitor #(.TUNE_W(TUNE_W), .PHASE_W(PHASE_W)) u_mon (
  .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .master_sync_en_i(master_sync_en_i),
  .osc_start_i(osc_start_i), .amp_dither_en_o(amp_dither_en_o),
  .phase_dither_en_o(phase_dither_en_o), .low_latency_sel_o(low_latency_sel_o),
  .tuning_word_o(tuning_word_o), .phase_offset_o(phase_offset_o),
  .accum_load_o(accum_load_o), .quarter_sync_o(quarter_sync_o),
  .filter_sync_o(filter_sync_o));

`default_nettype wire

// ### tb/ddcns_ctrl_tb_top.sv
// self-checking bench for the downconverter sync control register bank
`timescale 1ns/100ps
`default_nettype none

module ddcns_ctrl_tb_top;
  logic              clock_i = 1'b0;   // sample clock
  logic              nrst_i = 1'b0;    // reset, active low
  logic              ce_i = 1'b1;      // clock enable, low only around one write
  logic [7:0]        reg_addr_i = '0;  // offset
  logic [7:0]        reg_wdata_i = '0; // write data
  logic              reg_wr_i = 1'b0;  // write strobe
  logic              reg_rd_i = 1'b0;  // read strobe
  logic              master_sync_en_i = 1'b0; // master enable
  logic              osc_start_i = 1'b0;      // start pulse
  logic              align_pin_i = 1'b0;      // alignment pin
  logic [7:0]        reg_rdata_o;      // read data
  logic              amp_dither_en_o;  // amplitude dither
  logic              phase_dither_en_o; // phase dither
  logic              spectral_rev_o;   // spectral reversal
  logic              quarter_link_en_o; // tunable to quarter-rate sync
  logic              low_latency_sel_o; // low-latency select
  logic signed [31:0] tuning_word_o;   // tuning word
  logic [15:0]       phase_offset_o;   // phase offset
  logic              accum_load_o;     // accumulator load
  logic              quarter_sync_o;   // quarter-rate sync
  logic              filter_sync_o;    // filter sync
  int                n_fail = 0;       // mismatches
  int                n_tests = 0;      // comparisons
  int                cycles = 0;       // timeout counter
  int                na, nq, nf, first; // pulse counts, first load cycle
  logic [7:0]        rst_tab [10] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'h00, 8'h00, 8'h00, 8'h01}; // reset reads
  logic [7:0]        ff_tab [10] = '{8'h77, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                                     8'hff, 8'hf3, 8'h03, 8'h01}; // reads after 0xff

  ddcns_ctrl uut (
    .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .master_sync_en_i(master_sync_en_i),
    .osc_start_i(osc_start_i), .align_pin_i(align_pin_i),
    .amp_dither_en_o(amp_dither_en_o), .phase_dither_en_o(phase_dither_en_o),
    .spectral_rev_o(spectral_rev_o), .quarter_link_en_o(quarter_link_en_o),
    .low_latency_sel_o(low_latency_sel_o),
    .tuning_word_o(tuning_word_o), .phase_offset_o(phase_offset_o),
    .accum_load_o(accum_load_o), .quarter_sync_o(quarter_sync_o),
    .filter_sync_o(filter_sync_o));

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, run needs well under a thousand cycles
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  // one register write, outputs settled on return
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask

  // one register read compared with an expected byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
    #1;
    check(reg_rdata_o, e);
  endtask

  // hold the pin high for hi cycles and count pulses on each sync output
  task automatic pin_run(input int hi);
    na = 0;
    nq = 0;
    nf = 0;
    first = -1;
    for (int i = 0; i < hi + 10; i++)
    begin
      @(posedge clock_i);
      align_pin_i <= (i < hi);
      #1;
      if (accum_load_o === 1'b1)
      begin
        na++;
        if (first < 0)
          first = i;
      end
      if (quarter_sync_o === 1'b1)
        nq++;
      if (filter_sync_o === 1'b1)
        nf++;
    end
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    #1;
    check(low_latency_sel_o, 1'b1);
    for (int i = 0; i < 10; i++)
      rd_chk(8'h51 + i[7:0], rst_tab[i]);
    rd_chk(8'h60, 8'h00);
    for (int i = 0; i < 10; i++)
      wr(8'h51 + i[7:0], 8'hff);
    for (int i = 0; i < 10; i++)
      rd_chk(8'h51 + i[7:0], ff_tab[i]);
    wr(8'h51, 8'h04);
    check({quarter_link_en_o, spectral_rev_o, amp_dither_en_o, phase_dither_en_o},
          4'b0010);
    wr(8'h51, 8'h02);
    check({amp_dither_en_o, phase_dither_en_o}, 2'b01);
    // a general tuning word needs the low-latency path off first
    wr(8'h5a, 8'h00);
    check(low_latency_sel_o, 1'b0);
    wr(8'h52, 8'h80);
    wr(8'h53, 8'h00);
    wr(8'h54, 8'h00);
    wr(8'h55, 8'h01);
    check(tuning_word_o, 32'h80000001);
    check(tuning_word_o < 0, 1'b1);
    wr(8'h56, 8'h12);
    wr(8'h57, 8'h34);
    check(phase_offset_o, 16'h1234);
    // clock enable low: a write is not taken
    @(posedge clock_i);
    ce_i <= 1'b0;
    wr(8'h57, 8'h00);
    check(phase_offset_o, 16'h1234);
    @(posedge clock_i);
    ce_i <= 1'b1;
    @(posedge clock_i);
    osc_start_i <= 1'b1;
    @(posedge clock_i);
    osc_start_i <= 1'b0;
    #1;
    check(accum_load_o, 1'b1);
    @(posedge clock_i);
    master_sync_en_i <= 1'b1;
    wr(8'h58, 8'h51);
    wr(8'h59, 8'h03);
    pin_run(6);
    check(na * 100 + nq * 10 + nf, 111);
    check(first < 6, 1'b1);
    wr(8'h59, 8'h02);
    pin_run(6);
    check(na * 100 + nq * 10 + nf, 111);
    check(first >= 6, 1'b1);
    wr(8'h59, 8'h00);
    pin_run(6);
    check(na * 100 + nq * 10 + nf, 666);
    @(posedge clock_i);
    master_sync_en_i <= 1'b0;
    pin_run(6);
    check(na * 100 + nq * 10 + nf, 0);
    @(posedge clock_i);
    master_sync_en_i <= 1'b1;
    wr(8'h58, 8'hf3);
    pin_run(6);
    check(na * 100 + nq * 10 + nf, 111);
    rd_chk(8'h58, 8'ha2);
    pin_run(6);
    check(na * 100 + nq * 10 + nf, 0);
    // low-latency path only with a quarter-rate tuning word
    wr(8'h52, 8'hc0);
    wr(8'h55, 8'h00);
    wr(8'h5a, 8'h01);
    check(tuning_word_o, 32'hc0000000);
    check(low_latency_sel_o, 1'b1);
    report_and_stop();
  end
endmodule

`default_nettype wire
